// ---- include/fbas_pkg.sv ----
// constants and register map for the fieldbus address strap select block
package fbas_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0]  REG_STATUS   = 8'h00;
    localparam logic [7:0]  REG_ADDR     = 8'h04;
    localparam logic [7:0]  REG_IDSEL    = 8'h08;
    localparam logic [7:0]  REG_ZERO     = 8'h0c;
    localparam logic [7:0]  REG_CFG      = 8'h10;
    localparam logic [7:0]  REG_PARAM    = 8'h14;
    // status field positions
    localparam int          ST_LOCAL     = 8;
    localparam int          ST_SIM       = 9;
    localparam int          ST_WLOCK     = 10;
    localparam int          ST_ZBUSY     = 11;
    localparam int          ST_ZDONE     = 12;
    localparam int          ST_LOADREQ   = 13;
    localparam int          ST_SAMPLED   = 14;
    localparam int          WR_ACYCLIC   = 31;
    // strap positions (switch n sits in bit n-1)
    localparam int          SW_SRC       = 7;
    localparam int          SW_SIM       = 0;
    localparam int          SW_WLOCK     = 1;
    // addresses
    localparam logic [6:0]  ADDR_DEFAULT = 7'h7e;
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;
    // identity selector choices and codes (code values arbitrary)
    localparam logic [1:0]  IDSEL_MFR    = 2'h0;
    localparam logic [1:0]  IDSEL_STD1   = 2'h1;
    localparam logic [1:0]  IDSEL_STD2   = 2'h2;
    localparam logic [15:0] ID_CODE_MFR  = 16'h1a2b;
    localparam logic [15:0] ID_CODE_STD1 = 16'h3c4d;
    localparam logic [15:0] ID_CODE_STD2 = 16'h5e6f;
    // zero adjustment countdown
    localparam logic [7:0]  ZERO_START   = 8'hff;
    localparam longint      ZERO_TIME_MS = 20000;
    localparam longint      CLK_KHZ      = 100000;
    localparam longint      ZERO_STEP_CYC_L = (ZERO_TIME_MS * CLK_KHZ) / 255;
    localparam logic [31:0] ZERO_STEP_CYC = ZERO_STEP_CYC_L[31:0];
endpackage

// ---- include/fbas_zero_if.sv ----
// carrier between the strap selector and the zero adjustment counter
`timescale 1ns/10ps
interface fbas_zero_if;
    logic       start;
    logic       busy;
    logic       done;
    logic [7:0] count;
    modport ctl (output start, input busy, input done, input count);
    modport cnt (input start, output busy, output done, output count);
endinterface

// ---- rtl/fbas_zero_counter.sv ----
// zero adjustment countdown from 255 to 0
`timescale 1ns/10ps
module fbas_zero_counter
    import fbas_pkg::*;
#(
    parameter logic [31:0] STEP_CYC = ZERO_STEP_CYC
) (
    input  wire logic  clk,
    input  wire logic  rstSync_b,
    fbas_zero_if.cnt   zif
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [7:0]  count;
        logic [31:0] tick;
    } fbas_zc_t;

    fbas_zc_t cur_ff, nxt_cur;

    // ========================================
    // countdown
    // ========================================
    // a start while busy restarts, so a second request never stacks
    always_comb begin
        nxt_cur = cur_ff;
        if (zif.start) begin
            nxt_cur.busy  = 1'b1;
            nxt_cur.done  = 1'b0;
            nxt_cur.count = ZERO_START;
            nxt_cur.tick  = '0;
        end else if (cur_ff.busy) begin
            if (cur_ff.tick >= STEP_CYC - 32'h1) begin
                nxt_cur.tick  = '0;
                nxt_cur.count = cur_ff.count - 8'h01;
                if (cur_ff.count == 8'h01) begin
                    nxt_cur.busy = 1'b0;
                    nxt_cur.done = 1'b1;
                end
            end else begin
                nxt_cur.tick = cur_ff.tick + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign zif.busy  = cur_ff.busy;
    assign zif.done  = cur_ff.done;
    assign zif.count = cur_ff.count;

    a_zero_finish: assert property (@(posedge clk) disable iff (!rstSync_b)
        cur_ff.busy && nxt_cur.count == 8'h00 && !zif.start |=> zif.done && !zif.busy)
        else $error("countdown reached zero without completing");
    a_zero_load: assert property (@(posedge clk) disable iff (!rstSync_b)
        zif.start |=> zif.busy && zif.count == 8'hff)
        else $error("countdown did not load 255");
    c_zero_done: cover property (@(posedge clk) disable iff (!rstSync_b) $rose(zif.done));
endmodule

// ---- rtl/fbas_strap_select.sv ----
// fieldbus node address and option strap selection
//
// Function
// - local address from switches 1-7, weights 1..64
// - switch 8 selects bus or local source
// - source switch sampled once at power-on
// - bus mode uses stored address, default 126
// - first variant bus mode accepts new address from bus/keys while connected
// - address kept in gateway store, fresh 126
// - replaced electronics load plug-in parameter store
// - identity selector, three choices, acyclic writes only
// - variant two: switch one enables simulation
// - variant two: switch two blocks parameter writes
// - variant two: address from link scheduler
// - zero adjust counts 255 to 0, ~20 s
`timescale 1ns/10ps
module fbas_strap_select
    import fbas_pkg::*;
#(
    parameter logic [31:0] ZERO_STEP = ZERO_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // straps and pins
    input  wire logic [7:0]  dipSwitch,
    input  wire logic        busConnected,
    input  wire logic        electronicsNew,
    input  wire logic        paramLoadAck,
    input  wire logic [6:0]  keyAddr,
    input  wire logic        keyAddrStb,
    // gateway nonvolatile store
    input  wire logic [6:0]  storeAddr,
    input  wire logic        storeValid,
    output logic             storeWrEn,
    output logic      [6:0]  storeWrData,
    // link scheduler (same clock)
    input  wire logic [6:0]  schedAddr,
    input  wire logic        schedAddrValid,
    // results
    output logic      [6:0]  nodeAddr,
    output logic             localMode,
    output logic      [15:0] identNumber,
    output logic             simEnable,
    output logic             writeProtect,
    output logic             paramLoadReq,
    output logic             paramWrEn,
    output logic      [7:0]  paramWrData
);
    typedef struct packed {
        logic [7:0]  sw1, sw2;
        logic [6:0]  key1, key2;
        logic [2:0]  pin1, pin2;     // conn, new electronics, load ack
        logic        keyStb1, keyStb2, keyStbPrev;
        logic [1:0]  waitCnt;
        logic        sampled;
        logic        localMode;
        logic        variantTwo;
        logic [6:0]  nodeAddr;
        logic [1:0]  idSel;
        logic [15:0] ident;
        logic        loadReq;
        logic        storeWr;
        logic [6:0]  storeData;
        logic        paramWr;
        logic [7:0]  paramData;
        logic [7:0]  rejectCnt;
        logic        zeroStart;
        logic [31:0] rdData;
    } fbas_state_t;

    fbas_state_t st_ff, nxt_st;
    logic [1:0]  rstPipe_ff;
    logic        rstSync_b;
    fbas_zero_if zif ();

    function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // address change allowed only in first variant, bus source, on the bus
    function automatic logic addrChangeOk(input fbas_state_t s);
        return s.sampled && !s.variantTwo && !s.localMode && s.pin2[0];
    endfunction

    // ========================================
    // reset release
    // ========================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_ff <= 2'b00;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe_ff[1];

    fbas_zero_counter #(
        .STEP_CYC  (ZERO_STEP)
    ) u_zero (
        .clk       (clk),
        .rstSync_b (rstSync_b),
        .zif       (zif)
    );

    // ========================================
    // next state
    // ========================================
    always_comb begin
        logic keyEdge;
        logic wrLock;
        keyEdge = 1'b0;
        wrLock  = 1'b0;
        nxt_st  = st_ff;
        // pin synchronisers; only stage two and the strobe's third stage are ever read
        nxt_st.sw1     = dipSwitch;
        nxt_st.sw2     = st_ff.sw1;
        nxt_st.key1    = keyAddr;
        nxt_st.key2    = st_ff.key1;
        nxt_st.pin1    = {paramLoadAck, electronicsNew, busConnected};
        nxt_st.pin2    = st_ff.pin1;
        nxt_st.keyStb1 = keyAddrStb;
        nxt_st.keyStb2 = st_ff.keyStb1;
        nxt_st.keyStbPrev = st_ff.keyStb2;
        keyEdge        = st_ff.keyStb2 && !st_ff.keyStbPrev;
        wrLock         = st_ff.variantTwo && st_ff.sw2[SW_WLOCK];
        nxt_st.storeWr   = 1'b0;
        nxt_st.paramWr   = 1'b0;
        nxt_st.zeroStart = 1'b0;
        nxt_st.rdData    = '0;

        // power-on sampling once the synchronisers have filled
        if (!st_ff.sampled) begin
            if (st_ff.waitCnt == STRAP_WAIT) begin
                nxt_st.sampled   = 1'b1;
                nxt_st.localMode = st_ff.sw2[SW_SRC];
                if (st_ff.sw2[SW_SRC]) begin
                    nxt_st.nodeAddr = st_ff.sw2[6:0];
                end else if (storeValid) begin
                    nxt_st.nodeAddr = storeAddr;
                end else begin
                    nxt_st.nodeAddr = ADDR_DEFAULT;
                end
                nxt_st.loadReq = st_ff.pin2[1];
            end else begin
                nxt_st.waitCnt = st_ff.waitCnt + 2'h1;
            end
        end

        // plug-in store load handshake ends on the acknowledge
        if (st_ff.loadReq && st_ff.pin2[2]) begin
            nxt_st.loadReq = 1'b0;
        end

        // second variant takes its address from the link scheduler
        if (st_ff.sampled && st_ff.variantTwo && schedAddrValid) begin
            nxt_st.nodeAddr = schedAddr;
        end

        // key entry of a new address
        if (keyEdge && addrChangeOk(st_ff)) begin
            nxt_st.nodeAddr  = st_ff.key2;
            nxt_st.storeWr   = 1'b1;
            nxt_st.storeData = st_ff.key2;
        end

        // register writes; a bus write overrides a key in the same cycle
        if (regWr) begin
            if (regHit(regAddr, REG_ADDR)) begin
                if (addrChangeOk(st_ff)) begin
                    nxt_st.nodeAddr  = regWrData[6:0];
                    nxt_st.storeWr   = 1'b1;
                    nxt_st.storeData = regWrData[6:0];
                end
            end else if (regHit(regAddr, REG_IDSEL)) begin
                // cyclic traffic and undefined choices leave it unchanged
                if (regWrData[WR_ACYCLIC] && regWrData[1:0] != 2'h3) begin
                    nxt_st.idSel = regWrData[1:0];
                end
            end else if (regHit(regAddr, REG_ZERO)) begin
                nxt_st.zeroStart = regWrData[0];
            end else if (regHit(regAddr, REG_CFG)) begin
                nxt_st.variantTwo = regWrData[0];
            end else if (regHit(regAddr, REG_PARAM)) begin
                if (wrLock) begin
                    nxt_st.rejectCnt = st_ff.rejectCnt + 8'h01;
                end else begin
                    nxt_st.paramWr   = 1'b1;
                    nxt_st.paramData = regWrData[7:0];
                end
            end
        end

        // register reads, data in the following cycle
        if (regRd) begin
            if (regHit(regAddr, REG_STATUS)) begin
                nxt_st.rdData[6:0]        = st_ff.nodeAddr;
                nxt_st.rdData[ST_LOCAL]   = st_ff.localMode;
                nxt_st.rdData[ST_SIM]     = st_ff.variantTwo && st_ff.sw2[SW_SIM];
                nxt_st.rdData[ST_WLOCK]   = wrLock;
                nxt_st.rdData[ST_ZBUSY]   = zif.busy;
                nxt_st.rdData[ST_ZDONE]   = zif.done;
                nxt_st.rdData[ST_LOADREQ] = st_ff.loadReq;
                nxt_st.rdData[ST_SAMPLED] = st_ff.sampled;
            end else if (regHit(regAddr, REG_ADDR)) begin
                nxt_st.rdData[6:0] = st_ff.nodeAddr;
            end else if (regHit(regAddr, REG_IDSEL)) begin
                nxt_st.rdData[1:0] = st_ff.idSel;
            end else if (regHit(regAddr, REG_ZERO)) begin
                nxt_st.rdData[7:0] = zif.count;
                nxt_st.rdData[8]   = zif.busy;
                nxt_st.rdData[9]   = zif.done;
            end else if (regHit(regAddr, REG_CFG)) begin
                nxt_st.rdData[0] = st_ff.variantTwo;
            end else if (regHit(regAddr, REG_PARAM)) begin
                nxt_st.rdData[7:0] = st_ff.rejectCnt;
            end
        end

        // identity number held in a flop beside its selector, so the pins never glitch
        case (nxt_st.idSel)
            IDSEL_STD1: nxt_st.ident = ID_CODE_STD1;
            IDSEL_STD2: nxt_st.ident = ID_CODE_STD2;
            default:    nxt_st.ident = ID_CODE_MFR;
        endcase
    end

    // ========================================
    // state register
    // ========================================
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            st_ff          <= '0;
            st_ff.nodeAddr <= ADDR_DEFAULT;
            st_ff.idSel    <= IDSEL_MFR;
            st_ff.ident    <= ID_CODE_MFR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================
    // outputs
    // ========================================
    assign zif.start    = st_ff.zeroStart;
    assign regRdData    = st_ff.rdData;
    assign nodeAddr     = st_ff.nodeAddr;
    assign localMode    = st_ff.localMode;
    assign storeWrEn    = st_ff.storeWr;
    assign storeWrData  = st_ff.storeData;
    assign paramLoadReq = st_ff.loadReq;
    assign paramWrEn    = st_ff.paramWr;
    assign paramWrData  = st_ff.paramData;
    // option straps follow the switches continuously in the second variant
    assign simEnable    = st_ff.variantTwo && st_ff.sw2[SW_SIM];
    assign writeProtect = st_ff.variantTwo && st_ff.sw2[SW_WLOCK];
    assign identNumber  = st_ff.ident;

    // ========================================
    // checks
    // ========================================
    a_local_addr: assert property (@(posedge clk) disable iff (!rstSync_b)
        !st_ff.sampled && st_ff.waitCnt == STRAP_WAIT && st_ff.sw2[SW_SRC]
        |=> localMode && nodeAddr == $past(st_ff.sw2[6:0]))
        else $error("local address not taken from switches");
    a_src_strap: assert property (@(posedge clk) disable iff (!rstSync_b)
        !st_ff.sampled && st_ff.waitCnt == STRAP_WAIT |=> localMode == $past(st_ff.sw2[SW_SRC]))
        else $error("source strap not honoured");
    a_strap_once: assert property (@(posedge clk) disable iff (!rstSync_b)
        st_ff.sampled |=> $stable(localMode))
        else $error("source mode changed after power-on");
    a_default_addr: assert property (@(posedge clk) disable iff (!rstSync_b)
        !st_ff.sampled && st_ff.waitCnt == STRAP_WAIT && !st_ff.sw2[SW_SRC] && !storeValid
        |=> nodeAddr == 7'h7e)
        else $error("fresh store did not give 126");
    a_bus_addr: assert property (@(posedge clk) disable iff (!rstSync_b)
        regWr && regAddr == REG_ADDR && addrChangeOk(st_ff)
        |=> nodeAddr == $past(regWrData[6:0]) && storeWrEn)
        else $error("bus address write not taken");
    a_local_fixed: assert property (@(posedge clk) disable iff (!rstSync_b)
        st_ff.sampled && localMode && !st_ff.variantTwo |=> $stable(nodeAddr))
        else $error("local address moved in operation");
    a_load_req: assert property (@(posedge clk) disable iff (!rstSync_b)
        !st_ff.sampled && st_ff.waitCnt == STRAP_WAIT && st_ff.pin2[1] |=> paramLoadReq)
        else $error("replaced electronics did not request a load");
    a_id_cyclic: assert property (@(posedge clk) disable iff (!rstSync_b)
        regWr && regAddr == REG_IDSEL && !regWrData[WR_ACYCLIC] |=> $stable(identNumber))
        else $error("cyclic write changed identity selector");
    a_wlock_block: assert property (@(posedge clk) disable iff (!rstSync_b)
        writeProtect && regWr && regAddr == REG_PARAM |=> !paramWrEn)
        else $error("locked parameter write passed");
    a_sim_strap: assert property (@(posedge clk) disable iff (!rstSync_b)
        simEnable |-> st_ff.variantTwo && $past(dipSwitch[SW_SIM], 2))
        else $error("simulation enabled without strap");
    a_sched_addr: assert property (@(posedge clk) disable iff (!rstSync_b)
        st_ff.sampled && st_ff.variantTwo && schedAddrValid && !regWr |=> nodeAddr == $past(schedAddr))
        else $error("scheduler address not adopted");
    c_local_boot: cover property (@(posedge clk) disable iff (!rstSync_b) $rose(st_ff.sampled) && localMode);
    c_bus_write: cover property (@(posedge clk) disable iff (!rstSync_b) storeWrEn);
    c_locked_write: cover property (@(posedge clk) disable iff (!rstSync_b)
        writeProtect && regWr && regAddr == REG_PARAM);
endmodule

// ---- sim/fbas_store_model.sv ----
// behavioural model of the gateway nonvolatile store that keeps the node address
`timescale 1ns/10ps
module fbas_store_model
    import fbas_pkg::*;
#(
    parameter logic [6:0] SHIP_ADDR = ADDR_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       storeWrEn,
    input  wire logic [6:0] storeWrData,
    output logic      [6:0] storeAddr,
    output logic            storeValid
);
    // =====================================================
    // store contents
    // no reset input: contents must survive a power cycle of the block
    logic [6:0] keptAddr_ff = SHIP_ADDR; // shipped value until first write
    logic       keptValid_ff = 1'b0;     // blank until first write, so the 126 fallback runs

    // persist each address the block hands over
    always_ff @(posedge clk) begin
        if (storeWrEn === 1'b1) begin
            keptAddr_ff <= storeWrData; // kept for later power-ups
            keptValid_ff <= 1'b1;
        end
    end

    // contents readable, valid once written
    assign storeAddr  = keptAddr_ff;
    assign storeValid = keptValid_ff;
endmodule

// ---- sim/testbench.sv ----
// self-checking testbench for the fieldbus address strap select block
`timescale 1ns/10ps
module testbench
    import fbas_pkg::*;
;
    // =====================================================
    // signals
    localparam int STEP = 4; // shortened zero adjustment step
    logic        clk;
    logic        rst_b;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdData;
    logic [7:0]  dipSwitch;
    logic        busConnected;
    logic        electronicsNew;
    logic        paramLoadAck;
    logic [6:0]  keyAddr;
    logic        keyAddrStb;
    logic [6:0]  storeAddr;
    logic        storeValid;
    logic        storeWrEn;
    logic [6:0]  storeWrData;
    logic [6:0]  schedAddr;
    logic        schedAddrValid;
    logic [6:0]  nodeAddr;
    logic        localMode;
    logic [15:0] identNumber;
    logic        simEnable;
    logic        writeProtect;
    logic        paramLoadReq;
    logic        paramWrEn;
    logic [7:0]  paramWrData;
    logic [31:0] rd;
    logic        sawParamWr;
    logic [7:0]  lastParam;
    int          fails;
    int          checked;
    int          cycles;
    int          t0;
    logic [6:0]  weights [7] = '{7'd1, 7'd2, 7'd4, 7'd8, 7'd16, 7'd32, 7'd64};
    logic [15:0] codes [3];

    // =====================================================
    // design and far side
    fbas_strap_select #(.ZERO_STEP(32'(STEP))) u_dut (
        .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .dipSwitch(dipSwitch), .busConnected(busConnected),
        .electronicsNew(electronicsNew), .paramLoadAck(paramLoadAck), .keyAddr(keyAddr),
        .keyAddrStb(keyAddrStb), .storeAddr(storeAddr), .storeValid(storeValid), .storeWrEn(storeWrEn),
        .storeWrData(storeWrData), .schedAddr(schedAddr), .schedAddrValid(schedAddrValid),
        .nodeAddr(nodeAddr), .localMode(localMode), .identNumber(identNumber), .simEnable(simEnable),
        .writeProtect(writeProtect), .paramLoadReq(paramLoadReq), .paramWrEn(paramWrEn),
        .paramWrData(paramWrData)
    );
    fbas_store_model u_store (
        .clk(clk), .storeWrEn(storeWrEn), .storeWrData(storeWrData),
        .storeAddr(storeAddr), .storeValid(storeValid)
    );

    // =====================================================
    // clock, timeout and parameter write monitor
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is about 1300 cycles, so the 20000-cycle limit only trips on a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            $display("[ERR] run timed out");
            test_done();
        end
        if (paramWrEn === 1'b1) begin
            sawParamWr <= 1'b1;
            lastParam  <= paramWrData;
        end
    end

    // =====================================================
    // access tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask
    // read data is taken in the one cycle after the strobe
    task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // power cycle with given straps, then wait for the strap sample
    task automatic powerUp(input logic [7:0] sw, input logic newElec);
        int n;
        @(posedge clk);
        rst_b          <= 1'b0;
        dipSwitch      <= sw;
        electronicsNew <= newElec;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd = '0;
        for (n = 0; n < 20 && rd[ST_SAMPLED] !== 1'b1; n++) rdReg(REG_STATUS, rd);
        chk("sampled", 32'd1, 32'(rd[ST_SAMPLED]));
    endtask
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // =====================================================
    // test sequence
    initial begin
        {regAddr, regWrData, regWr, regRd, dipSwitch, electronicsNew, paramLoadAck} = '0;
        {keyAddr, keyAddrStb, schedAddr, schedAddrValid, sawParamWr, lastParam} = '0;
        rst_b = 1'b0;
        busConnected = 1'b1;
        fails = 0;
        checked = 0;
        cycles = 0;
        codes = '{ID_CODE_MFR, ID_CODE_STD1, ID_CODE_STD2};
        // fresh electronics, bus mode, shipped address
        powerUp(8'h00, 1'b1);
        chk("node addr", 32'd126, 32'(nodeAddr));
        chk("local mode", 32'd0, 32'(localMode));
        chk("ident", 32'(ID_CODE_MFR), 32'(identNumber));
        chk("load req", 32'd1, 32'(paramLoadReq));
        paramLoadAck <= 1'b1;
        repeat (5) @(posedge clk);
        chk("load req", 32'd0, 32'(paramLoadReq));
        paramLoadAck <= 1'b0;
        $display("test defaults done");
        // bus write, persistence, key entry, disconnected refusal
        wr(REG_ADDR, 32'h5);
        repeat (2) @(posedge clk);
        chk("node addr", 32'h5, 32'(nodeAddr));
        powerUp(8'h00, 1'b0);
        chk("node addr", 32'h5, 32'(nodeAddr));
        keyAddr    <= 7'h2a;
        keyAddrStb <= 1'b1;
        repeat (6) @(posedge clk);
        keyAddrStb <= 1'b0;
        chk("node addr", 32'h2a, 32'(nodeAddr));
        busConnected <= 1'b0;
        repeat (4) @(posedge clk);
        wr(REG_ADDR, 32'h11);
        repeat (2) @(posedge clk);
        chk("node addr", 32'h2a, 32'(nodeAddr));
        busConnected <= 1'b1;
        $display("test bus address done");
        // local mode: each switch weight, then one mixed pattern
        for (int i = 0; i < 7; i++) begin
            powerUp(8'h80 | (8'h1 << i), 1'b0);
            chk("node addr", 32'(weights[i]), 32'(nodeAddr));
            chk("local mode", 32'd1, 32'(localMode));
        end
        powerUp(8'hd5, 1'b0);
        chk("node addr", 32'(weights[0] + weights[2] + weights[4] + weights[6]), 32'(nodeAddr));
        dipSwitch <= 8'h0a;
        repeat (6) @(posedge clk);
        wr(REG_ADDR, 32'h3);
        rdReg(REG_STATUS, rd);
        chk("status addr", 32'd85, 32'(rd[6:0]));
        chk("status local", 32'd1, 32'(rd[ST_LOCAL]));
        $display("test local switches done");
        // identity selector, acyclic only, illegal choice refused
        powerUp(8'h00, 1'b0);
        wr(REG_IDSEL, 32'h1);
        repeat (2) @(posedge clk);
        chk("ident", 32'(ID_CODE_MFR), 32'(identNumber));
        for (int s = 1; s < 3; s++) begin
            wr(REG_IDSEL, 32'h80000000 | 32'(s));
            repeat (2) @(posedge clk);
            chk("ident", 32'(codes[s]), 32'(identNumber));
        end
        wr(REG_IDSEL, 32'h80000003);
        repeat (2) @(posedge clk);
        chk("ident", 32'(ID_CODE_STD2), 32'(identNumber));
        wr(REG_IDSEL, 32'h80000000);
        rdReg(REG_IDSEL, rd);
        chk("idsel", 32'(IDSEL_MFR), 32'(rd[1:0]));
        $display("test identity done");
        // second variant: simulation, write lock, scheduler address
        wr(REG_CFG, 32'h1);
        rdReg(REG_CFG, rd);
        chk("cfg", 32'd1, rd);
        dipSwitch <= 8'h01;
        repeat (5) @(posedge clk);
        chk("sim enable", 32'd1, 32'(simEnable));
        chk("write protect", 32'd0, 32'(writeProtect));
        sawParamWr <= 1'b0;
        wr(REG_PARAM, 32'h5a);
        repeat (2) @(posedge clk);
        chk("param write", 32'd1, 32'(sawParamWr));
        chk("param data", 32'h5a, 32'(lastParam));
        dipSwitch <= 8'h02;
        repeat (5) @(posedge clk);
        chk("sim enable", 32'd0, 32'(simEnable));
        chk("write protect", 32'd1, 32'(writeProtect));
        sawParamWr <= 1'b0;
        wr(REG_PARAM, 32'ha5);
        repeat (2) @(posedge clk);
        chk("param write", 32'd0, 32'(sawParamWr));
        rdReg(REG_PARAM, rd);
        chk("reject count", 32'd1, rd);
        rdReg(REG_STATUS, rd);
        chk("status options", 32'h2, 32'(rd[ST_WLOCK:ST_SIM]));
        schedAddr      <= 7'h23;
        schedAddrValid <= 1'b1;
        repeat (3) @(posedge clk);
        chk("node addr", 32'h23, 32'(nodeAddr));
        rdReg(REG_ADDR, rd);
        chk("addr reg", 32'h23, rd);
        schedAddrValid <= 1'b0;
        dipSwitch      <= 8'h00;
        wr(REG_CFG, 32'h0);
        $display("test variant two done");
        // zero adjustment countdown from 255 to 0
        t0 = cycles;
        wr(REG_ZERO, 32'h1);
        rdReg(REG_ZERO, rd);
        chk("zero start", 32'h1ff, 32'(rd[9:0]));
        for (int n = 0; n < 600 && rd[9] !== 1'b1; n++) rdReg(REG_ZERO, rd);
        chk("zero end", 32'h200, 32'(rd[9:0]));
        chk("zero span", 32'd1, 32'((cycles - t0 >= 255 * STEP) && (cycles - t0 <= 255 * STEP + 16)));
        rdReg(8'h3c, rd);
        chk("unmapped", 32'd0, rd);
        $display("test zero adjust done");
        test_done();
    end
endmodule
